// ### rtl/cod_decoder.sv
/*
 * Control-class instruction decoder. Registers one pulse per recognised
 * operation together with the operand fields of the word.
 * Assumes the fetch stage drives word_valid and word on sys_clk, and that
 * execution units consume the registered outputs one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module cod_decoder (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        word_valid,
	input  wire logic [15:0] word,
	output logic             test_bit_by_treg,
	output logic             block_to_data_space,
	output logic             block_to_program_space,
	output logic             load_status_zero,
	output logic             load_status_one,
	output logic             store_status_zero,
	output logic             store_status_one,
	output logic             stack_pop_to_acc,
	output logic             stack_push_from_acc,
	output logic             stack_pop_to_mem,
	output logic             stack_push_from_mem,
	output logic             repeat_from_mem,
	output logic             repeat_from_immediate,
	output logic             mem_operand,
	output logic             indirect_sel,
	output logic      [6:0]  addr_field,
	output logic      [7:0]  imm_field,
	output logic             claimed,
	output logic             single_word
);

	logic [12:0] ops_d;
	logic [12:0] ops_q;
	logic        mem_d;
	logic        mem_q;
	logic        ind_q;
	logic [6:0]  addr_q;
	logic [7:0]  imm_q;

	// ------------------------------------------------------------------
	// Pattern match
	// ------------------------------------------------------------------

	// Matcher compares the raw word against every control pattern.
	cod_match u_match (
		.word (word),
		.ops  (ops_d)
	);

	// Forms that carry a direct or indirect data-memory operand.
	assign mem_d = ops_d[cod_pkg::OP_TEST_BIT_TREG]
		| ops_d[cod_pkg::OP_LOAD_ST_ZERO]
		| ops_d[cod_pkg::OP_LOAD_ST_ONE]
		| ops_d[cod_pkg::OP_STORE_ST_ZERO]
		| ops_d[cod_pkg::OP_STORE_ST_ONE]
		| ops_d[cod_pkg::OP_POP_TO_MEM]
		| ops_d[cod_pkg::OP_PUSH_FROM_MEM]
		| ops_d[cod_pkg::OP_REPEAT_MEM];

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------

	// Operation pulses; an idle cycle or unmatched word clears them all.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ops_q <= cod_pkg::OPS_RST;
		end else if (word_valid) begin
			ops_q <= ops_d;
		end else begin
			ops_q <= cod_pkg::OPS_RST;
		end
	end

	// Memory-operand qualifier follows the operation pulses.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mem_q <= 1'b0;
		end else begin
			mem_q <= word_valid & mem_d;
		end
	end

	// Operand fields are captured unchanged from every valid word.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ind_q  <= 1'b0;
			addr_q <= cod_pkg::ADDR_RST;
			imm_q  <= cod_pkg::IMM_RST;
		end else if (word_valid) begin
			ind_q  <= word[cod_pkg::IND_BIT];
			addr_q <= word[cod_pkg::ADDR_MSB:cod_pkg::ADDR_LSB];
			imm_q  <= word[cod_pkg::IMM_MSB:cod_pkg::IMM_LSB];
		end
	end

	// ------------------------------------------------------------------
	// Output mapping
	// ------------------------------------------------------------------

	// Named pulses taken from the registered one-hot vector.
	assign test_bit_by_treg       = ops_q[cod_pkg::OP_TEST_BIT_TREG];
	assign block_to_data_space    = ops_q[cod_pkg::OP_BLOCK_DATA];
	assign block_to_program_space = ops_q[cod_pkg::OP_BLOCK_PROG];
	assign load_status_zero       = ops_q[cod_pkg::OP_LOAD_ST_ZERO];
	assign load_status_one        = ops_q[cod_pkg::OP_LOAD_ST_ONE];
	assign store_status_zero      = ops_q[cod_pkg::OP_STORE_ST_ZERO];
	assign store_status_one       = ops_q[cod_pkg::OP_STORE_ST_ONE];
	assign stack_pop_to_acc       = ops_q[cod_pkg::OP_POP_ACC];
	assign stack_push_from_acc    = ops_q[cod_pkg::OP_PUSH_ACC];
	assign stack_pop_to_mem       = ops_q[cod_pkg::OP_POP_TO_MEM];
	assign stack_push_from_mem    = ops_q[cod_pkg::OP_PUSH_FROM_MEM];
	assign repeat_from_mem        = ops_q[cod_pkg::OP_REPEAT_MEM];
	assign repeat_from_immediate  = ops_q[cod_pkg::OP_REPEAT_IMM];
	assign mem_operand            = mem_q;
	assign indirect_sel           = ind_q;
	assign addr_field             = addr_q;
	assign imm_field              = imm_q;

	// Every operation here is a one-word instruction.
	assign claimed     = |ops_q;
	assign single_word = |ops_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	// A valid word whose upper byte matches a pattern.
	sequence s_hi(logic [7:0] pat);
		word_valid && word[15:8] == pat;
	endsequence

	AST_TEST_BIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h57) |=> test_bit_by_treg && mem_operand && claimed)
		else $error("test bit form not decoded");

	AST_BLOCK_DATA: assert property (@(posedge sys_clk) disable iff (sys_rst)
		word_valid && word == 16'hCE04 |=> block_to_data_space
			&& !block_to_program_space && single_word)
		else $error("data space block command not decoded");

	AST_BLOCK_PROG: assert property (@(posedge sys_clk) disable iff (sys_rst)
		word_valid && word == 16'hCE05 |=> block_to_program_space
			&& !block_to_data_space)
		else $error("program space block command not decoded");

	AST_LOAD_ST0: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h50) |=> load_status_zero && !load_status_one
			&& addr_field == $past(word[6:0]))
		else $error("status zero load not decoded");

	AST_LOAD_ST1: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h51) |=> load_status_one && !load_status_zero)
		else $error("status one load not decoded");

	AST_STORE_ST0: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h78) |=> store_status_zero && indirect_sel == $past(word[7]))
		else $error("status zero store not decoded");

	AST_STORE_ST1: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h79) |=> store_status_one && single_word)
		else $error("status one store not decoded");

	AST_POP_ACC: assert property (@(posedge sys_clk) disable iff (sys_rst)
		word_valid && word == 16'hCE1D |=> stack_pop_to_acc
			&& !stack_push_from_acc && !mem_operand)
		else $error("accumulator pop not decoded");

	AST_PUSH_ACC: assert property (@(posedge sys_clk) disable iff (sys_rst)
		word_valid && word == 16'hCE1C |=> stack_push_from_acc
			&& !stack_pop_to_acc)
		else $error("accumulator push not decoded");

	AST_POP_MEM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h7A) |=> stack_pop_to_mem && mem_operand)
		else $error("pop to memory not decoded");

	AST_PUSH_MEM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h54) |=> stack_push_from_mem && mem_operand)
		else $error("push from memory not decoded");

	AST_RPT_MEM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'h4B) |=> repeat_from_mem && mem_operand
			&& indirect_sel == $past(word[7]))
		else $error("memory repeat not decoded");

	AST_RPT_IMM: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hi(8'hCB) |=> repeat_from_immediate && !mem_operand
			&& imm_field == $past(word[7:0]))
		else $error("immediate repeat not decoded");

	AST_FIELDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mem_operand |-> {indirect_sel, addr_field} == $past(word[7:0]))
		else $error("operand fields altered");

	AST_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!word_valid |=> !claimed && !mem_operand)
		else $error("operation asserted without a valid word");

	AST_ONEHOT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$onehot0(ops_q) && (claimed == (ops_q != 13'h0000)))
		else $error("more than one operation asserted");

endmodule

`default_nettype wire

// ### rtl/cod_match.sv
/*
 * Combinational pattern matcher: turns one instruction word into a
 * one-hot vector of control operations.
 * Assumes a 16-bit word that is stable in the cycle it is presented.
 */
`timescale 1ns/1ps
`default_nettype none

module cod_match (
	input  wire logic [15:0] word,
	output logic      [12:0] ops
);

	logic [7:0] hi;

	// ------------------------------------------------------------------
	// Pattern compare
	// ------------------------------------------------------------------

	// Upper byte used by the memory-operand and immediate forms.
	assign hi = word[cod_pkg::HI_MSB:cod_pkg::HI_LSB];

	// Each compare is independent; the patterns never overlap.
	always_comb begin
		ops = cod_pkg::OPS_RST;
		ops[cod_pkg::OP_TEST_BIT_TREG] = (hi == cod_pkg::HI_TEST_BIT_TREG);
		ops[cod_pkg::OP_BLOCK_DATA]    = (word == cod_pkg::W_BLOCK_DATA);
		ops[cod_pkg::OP_BLOCK_PROG]    = (word == cod_pkg::W_BLOCK_PROG);
		ops[cod_pkg::OP_LOAD_ST_ZERO]  = (hi == cod_pkg::HI_LOAD_ST_ZERO);
		ops[cod_pkg::OP_LOAD_ST_ONE]   = (hi == cod_pkg::HI_LOAD_ST_ONE);
		ops[cod_pkg::OP_STORE_ST_ZERO] = (hi == cod_pkg::HI_STORE_ST_ZERO);
		ops[cod_pkg::OP_STORE_ST_ONE]  = (hi == cod_pkg::HI_STORE_ST_ONE);
		ops[cod_pkg::OP_POP_ACC]       = (word == cod_pkg::W_POP_ACC);
		ops[cod_pkg::OP_PUSH_ACC]      = (word == cod_pkg::W_PUSH_ACC);
		ops[cod_pkg::OP_POP_TO_MEM]    = (hi == cod_pkg::HI_POP_TO_MEM);
		ops[cod_pkg::OP_PUSH_FROM_MEM] = (hi == cod_pkg::HI_PUSH_FROM_MEM);
		ops[cod_pkg::OP_REPEAT_MEM]    = (hi == cod_pkg::HI_REPEAT_MEM);
		ops[cod_pkg::OP_REPEAT_IMM]    = (hi == cod_pkg::HI_REPEAT_IMM);
	end

endmodule

`default_nettype wire

// ### rtl/cod_pkg.sv
/*
 * Constants for the control-class instruction decoder: opcode patterns,
 * operand field positions and decoder timing.
 * Assumes 16-bit instruction words presented by the fetch stage.
 */
`default_nettype none

package cod_pkg;

	// ------------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------------
	localparam int WORD_W       = 16;
	localparam int HI_MSB       = 15;
	localparam int HI_LSB       = 8;
	localparam int IND_BIT      = 7;
	localparam int ADDR_MSB     = 6;
	localparam int ADDR_LSB     = 0;
	localparam int IMM_MSB      = 7;
	localparam int IMM_LSB      = 0;
	localparam int DECODE_LAT   = 1;
	localparam int NUM_OPS      = 13;

	// ------------------------------------------------------------------
	// Upper byte patterns of memory-operand and immediate forms
	// ------------------------------------------------------------------
	localparam logic [7:0] HI_TEST_BIT_TREG = 8'h57;
	localparam logic [7:0] HI_LOAD_ST_ZERO  = 8'h50;
	localparam logic [7:0] HI_LOAD_ST_ONE   = 8'h51;
	localparam logic [7:0] HI_STORE_ST_ZERO = 8'h78;
	localparam logic [7:0] HI_STORE_ST_ONE  = 8'h79;
	localparam logic [7:0] HI_POP_TO_MEM    = 8'h7A;
	localparam logic [7:0] HI_PUSH_FROM_MEM = 8'h54;
	localparam logic [7:0] HI_REPEAT_MEM    = 8'h4B;
	localparam logic [7:0] HI_REPEAT_IMM    = 8'hCB;

	// ------------------------------------------------------------------
	// Complete word patterns
	// ------------------------------------------------------------------
	localparam logic [15:0] W_BLOCK_DATA = 16'hCE04;
	localparam logic [15:0] W_BLOCK_PROG = 16'hCE05;
	localparam logic [15:0] W_POP_ACC    = 16'hCE1D;
	localparam logic [15:0] W_PUSH_ACC   = 16'hCE1C;

	// ------------------------------------------------------------------
	// Operation select bit positions
	// ------------------------------------------------------------------
	localparam int OP_TEST_BIT_TREG = 0;
	localparam int OP_BLOCK_DATA    = 1;
	localparam int OP_BLOCK_PROG    = 2;
	localparam int OP_LOAD_ST_ZERO  = 3;
	localparam int OP_LOAD_ST_ONE   = 4;
	localparam int OP_STORE_ST_ZERO = 5;
	localparam int OP_STORE_ST_ONE  = 6;
	localparam int OP_POP_ACC       = 7;
	localparam int OP_PUSH_ACC      = 8;
	localparam int OP_POP_TO_MEM    = 9;
	localparam int OP_PUSH_FROM_MEM = 10;
	localparam int OP_REPEAT_MEM    = 11;
	localparam int OP_REPEAT_IMM    = 12;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [12:0] OPS_RST  = 13'h0000;
	localparam logic [6:0]  ADDR_RST = 7'h00;
	localparam logic [7:0]  IMM_RST  = 8'h00;

endpackage

`default_nettype wire

// ### sim/cod_fetch_model.sv
/*
 * Fetch stage model: presents one instruction word per cycle to the decoder.
 * Assumes the bench calls its tasks in order; each task takes one cycle and
 * changes the outputs just after a falling edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module cod_fetch_model (
	input  wire logic        sys_clk,
	output logic             word_valid,
	output logic      [15:0] word
);

	// ------------------------------------------------------------------
	// Word presentation
	// ------------------------------------------------------------------

	// Nothing is offered until the bench asks for a word.
	initial begin
		word_valid = 1'b0;
		word       = 16'h0000;
	end

	// Offers one fetched word for the next rising edge.
	task automatic send(input logic [15:0] w);
		@(negedge sys_clk);
		word_valid = 1'b1;
		word       = w;
	endtask

	// An idle bus does not keep its last word, so a stale capture shows up.
	task automatic idle();
		@(negedge sys_clk);
		word_valid = 1'b0;
		word       = ~word;
	endtask

endmodule

`default_nettype wire

// ### sim/tb_top.sv
/*
 * Self-checking bench for the control-class decoder: a table of words with
 * the decode each must give, after a reset case and before hold and mid-run reset cases.
 * Assumes the decoder answers exactly one cycle after a valid word.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_top;

	typedef struct packed {
		logic [15:0] w;
		logic [12:0] ops;
		logic        mem;
	} cod_row_t;

	logic        sys_clk, sys_rst, word_valid, mem_operand, indirect_sel;
	logic        claimed, single_word;
	logic [15:0] word;
	logic [12:0] ops;
	logic [6:0]  addr_field;
	logic [7:0]  imm_field;
	int          n_mismatch, checks;

	// Table of words, one per row; the last rows match nothing here.
	localparam cod_row_t ROWS [21] = '{
		'{16'h5785, 13'h0001, 1'b1}, '{16'hCE04, 13'h0002, 1'b0},
		'{16'hCE05, 13'h0004, 1'b0}, '{16'h5000, 13'h0008, 1'b1},
		'{16'h51FF, 13'h0010, 1'b1}, '{16'h7880, 13'h0020, 1'b1},
		'{16'h797F, 13'h0040, 1'b1}, '{16'hCE1D, 13'h0080, 1'b0},
		'{16'hCE1C, 13'h0100, 1'b0}, '{16'h7A2A, 13'h0200, 1'b1},
		'{16'h54D5, 13'h0400, 1'b1}, '{16'h4B01, 13'h0800, 1'b1},
		'{16'hCBFE, 13'h1000, 1'b0}, '{16'hCBFE, 13'h1000, 1'b0},
		'{16'h5500, 13'h0000, 1'b0}, '{16'hCE00, 13'h0000, 1'b0},
		'{16'hCE06, 13'h0000, 1'b0}, '{16'hCE1E, 13'h0000, 1'b0},
		'{16'h5600, 13'h0000, 1'b0}, '{16'h4E04, 13'h0000, 1'b0},
		'{16'h4A80, 13'h0000, 1'b0}};

	// ------------------------------------------------------------------
	// Clock, partner and decoder
	// ------------------------------------------------------------------

	// Free-running 100 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	cod_fetch_model fetch (.sys_clk(sys_clk), .word_valid(word_valid),
		.word(word));

	cod_decoder DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.word_valid(word_valid), .word(word),
		.test_bit_by_treg(ops[0]), .block_to_data_space(ops[1]),
		.block_to_program_space(ops[2]), .load_status_zero(ops[3]),
		.load_status_one(ops[4]), .store_status_zero(ops[5]),
		.store_status_one(ops[6]), .stack_pop_to_acc(ops[7]),
		.stack_push_from_acc(ops[8]), .stack_pop_to_mem(ops[9]),
		.stack_push_from_mem(ops[10]), .repeat_from_mem(ops[11]),
		.repeat_from_immediate(ops[12]), .mem_operand(mem_operand),
		.indirect_sel(indirect_sel), .addr_field(addr_field),
		.imm_field(imm_field), .claimed(claimed),
		.single_word(single_word));

	// ------------------------------------------------------------------
	// Checks and closing
	// ------------------------------------------------------------------

	// Compares the whole decode against what word w must give.
	task automatic check_all(input logic [15:0] w, input logic [12:0] e,
		input logic m);
		`CHK("ops", e, ops)
		`CHK("mem_operand", m, mem_operand)
		`CHK("indirect_sel", w[7], indirect_sel)
		`CHK("addr_field", w[6:0], addr_field)
		`CHK("imm_field", w[7:0], imm_field)
		`CHK("claimed", |e, claimed)
		`CHK("single_word", |e, single_word)
	endtask

	// Prints the verdict and stops the run.
	task automatic test_done();
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Cuts a hung run short and counts it as a mismatch.
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		test_done();
	end

	// Main sequence: reset, table, then the hand-written cases.
	initial begin
		n_mismatch = 0;
		checks     = 0;
		sys_rst    = 1'b1;
		repeat (6) @(negedge sys_clk);
		#1;
		check_all(16'h0000, 13'h0000, 1'b0);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		// Back to back words, one every cycle.
		foreach (ROWS[i]) begin
			fetch.send(ROWS[i].w);
			@(posedge sys_clk);
			#1;
			check_all(ROWS[i].w, ROWS[i].ops, ROWS[i].mem);
		end
		// Idle cycle clears the pulses but keeps the captured fields.
		fetch.send(16'h50FF);
		fetch.idle();
		@(posedge sys_clk);
		#1;
		`CHK("ops_idle", 13'h0000, ops)
		`CHK("addr_hold", 7'h7F, addr_field)
		// Reset in mid-run overrides a matching word.
		fetch.send(16'hCE04);
		fetch.send(16'hCE04);
		sys_rst = 1'b1;
		@(posedge sys_clk);
		#1;
		check_all(16'h0000, 13'h0000, 1'b0);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		fetch.send(16'h7AC3);
		@(posedge sys_clk);
		#1;
		check_all(16'h7AC3, 13'h0200, 1'b1);
		test_done();
	end

endmodule

`default_nettype wire
